/* src/ftc_pkg.sv */
/*
 Constants for the EL2 feature trap control block: register layout,
 field positions, exception class codes and instruction class encodings.
 Assumes the decode pipeline classifies each instruction before it asks.
*/
package ftc_pkg;
   localparam int          REG_W          = 64;
   localparam int          MATRIX_FLD_LO  = 24;
   localparam int          FLOAT_FLD_LO   = 20;
   localparam int          VECTOR_FLD_LO  = 16;
   localparam int          ACR_BIT        = 31;
   localparam int          AMU_BIT        = 30;
   localparam int          TRC_BIT_WIDE   = 28;
   localparam int          TRC_BIT_NARROW = 20;
   localparam int          MATRIX_BIT     = 12;
   localparam int          FLOAT_BIT      = 10;
   localparam int          VECTOR_BIT     = 8;
   // Writable masks per layout; everything else is reserved
   localparam logic [63:0] WIDE_WR_MASK   = 64'h0000_0000_D333_0000;
   localparam logic [63:0] NARROW_WR_MASK = 64'h0000_0000_C010_1500;
   // Reserved-one bits of the single-bit layout (bits 13, 9, 7:0)
   localparam logic [63:0] NARROW_RES1    = 64'h0000_0000_0000_22FF;
   localparam logic [63:0] RESET_VALUE    = 64'h0000_0000_0000_0000;
   localparam logic [1:0]  ENC_TRAP_ALL   = 2'h0;
   localparam logic [1:0]  ENC_TRAP_EL0   = 2'h1;
   localparam logic [1:0]  ENC_TRAP_NONE  = 2'h3;
   localparam logic [5:0]  EC_NONE        = 6'h00;
   localparam logic [5:0]  EC_WIDE32      = 6'h03;
   localparam logic [5:0]  EC_PAIR32      = 6'h04;
   localparam logic [5:0]  EC_TRACE32     = 6'h05;
   localparam logic [5:0]  EC_FLOAT       = 6'h07;
   localparam logic [5:0]  EC_SYSREG64    = 6'h18;
   localparam logic [5:0]  EC_VECTOR      = 6'h19;
   localparam logic [5:0]  EC_MATRIX      = 6'h1D;
   localparam logic [24:0] ISS_MATRIX     = 25'h0000000;
   localparam logic [1:0]  OP0_TRACE      = 2'h2;
   localparam logic [2:0]  OP1_TRACE      = 3'h1;
   localparam logic [3:0]  CRN_TRACE_LIM  = 4'h8;
   localparam logic [1:0]  EL0            = 2'h0;
   localparam logic [1:0]  EL1            = 2'h1;
   localparam logic [1:0]  EL2            = 2'h2;

   typedef enum logic [3:0] {
      ICLS_NONE,
      ICLS_MATRIX,       // matrix instr, streaming/no-feature vector instr, mode/matrix ctrl regs
      ICLS_SMODE_IMM,    // immediate-form writes of streaming mode / array storage
      ICLS_VECTOR,       // non-streaming vector instr, vector length regs
      ICLS_FLOAT,        // FP/SIMD register access
      ICLS_FLOAT_ID,     // FP id/media feature/FP exception control regs
      ICLS_FLOAT_ID_WR,  // register-transfer write to FP id reg
      ICLS_ACR,          // EL1 access control register
      ICLS_AMU,          // activity monitor single access
      ICLS_AMU_PAIR,     // activity monitor paired transfer (32-bit state)
      ICLS_TRACE         // trace system register access
   } ftc_icls_t;
endpackage

/* src/ftc_el2_feature_trap_control.sv */
/*
 EL2 feature trap control register with trap decision logic.
 Assumes the pipeline presents one classified instruction per cycle
 and takes the registered verdict one cycle later.
*/
`timescale 1ns/1ps
// How it works
// - Two-bit layout when host extension present and host-in-EL2 set, else single-bit.
// - Two-bit matrix field 25:24 traps matrix work and mode/matrix ctrl registers.
// - Two-bit encoding: 00/10 trap all, 11 none, 01 traps EL0 only under TGE.
// - Matrix traps report class 0x1D with zero syndrome detail.
// - Immediate streaming mode writes trap whenever mode control register access traps.
// - Matrix control never touches register validity; it only decides trapping.
// - Matrix or vector trap beats floating-point trap in two-bit layout.
// - Two-bit float field 21:20 traps FP/SIMD and matrix/vector work, class 0x07.
// - EL0 access to FP id/feature/exception regs is undefined, above float trap.
// - Two-bit vector field 17:16 traps non-streaming vector work, class 0x19.
// - Bit 31 traps EL1 access control register access; class 0x18 or 0x03.
// - Host-trap-general set disables the access control register trap.
// - Bit 30 traps EL1/EL0 activity monitor access; class 0x18, 0x03, 0x04.
// - Trace trap catches op0=2, op1=1, CRn below 8; class 0x18 or 0x05.
// - Trapped trace access gets no side effect; bit zero when unsupported.
// - EL0 trace undefined when forbidden, outranks trap; memory-mapped never trapped.
// - Single-bit matrix bit 12: 0 traps none, 1 traps EL2, EL1, EL0.
// - Single-bit: matrix or vector trap beats floating-point trap.
// - Single-bit float bit 10 traps FP/SIMD and matrix/vector work, class 0x07.
// - FP id register transfer write from EL1+ counts as FP access, else undefined.
// - Trap fields are unknown after warm reset; software must write first.
module ftc_el2_feature_trap_control
   import ftc_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        matrixFeaturePresent,
   input  wire logic        vectorFeaturePresent,
   input  wire logic        hostExtensionPresent,
   input  wire logic        activityMonitorPresent,
   input  wire logic        traceSysregPresent,
   input  wire logic        hostInEl2,
   input  wire logic        hostTrapGeneral,
   input  wire logic        el2Enabled,
   input  wire logic        traceEl0Forbidden,
   input  wire logic        regWrEn,
   input  wire logic [63:0] regWrData,
   input  wire logic        instValid,
   input  wire ftc_icls_t   instClass,
   input  wire logic [1:0]  instEl,
   input  wire logic        instState32,
   input  wire logic [1:0]  instOp0,
   input  wire logic [2:0]  instOp1,
   input  wire logic [3:0]  instCrn,
   output logic [63:0]      regRdData,
   output logic             trapValid,
   output logic [5:0]       exceptionClass,
   output logic [24:0]      syndromeDetail,
   output logic             undefValid,
   output logic             sideEffectEn
);
   typedef struct packed {
      logic [63:0] ctrl;
      logic [63:0] rd;
      logic        trap;
      logic [5:0]  ec;
      logic [24:0] syndrome_detail;
      logic        undef;
      logic        side;
   } ftc_state_t;

   ftc_state_t stateFf;
   ftc_state_t nxtState;

   // Two-bit field decode, shared by matrix, float and vector fields
   function automatic logic fld_traps(input logic [1:0] f, input logic [1:0] el, input logic tge);
      fld_traps = 1'b0;
      case (f)
         ENC_TRAP_NONE: fld_traps = 1'b0;
         ENC_TRAP_EL0:  fld_traps = tge && (el == EL0);
         default:       fld_traps = 1'b1;
      endcase
   endfunction

   logic        wide;
   logic [63:0] wrMask;
   logic [63:0] res1;
   logic        trcBit;
   logic        isTraceEnc;
   logic        mtxTrap;
   logic        vecTrap;
   logic        fltTrap;
   logic        fltCls;

   always_comb begin
      wide   = hostExtensionPresent && hostInEl2;
      wrMask = wide ? WIDE_WR_MASK : NARROW_WR_MASK;
      res1   = wide ? 64'h0000_0000_0000_0000 : NARROW_RES1;
      // Unsupported features pin their bits to reserved values
      if (!matrixFeaturePresent) begin
         wrMask[MATRIX_FLD_LO +: 2] = 2'h0;
         wrMask[MATRIX_BIT]         = 1'b0;
         if (!wide) begin
            res1[MATRIX_BIT] = 1'b1;
         end
      end
      if (!vectorFeaturePresent) begin
         wrMask[VECTOR_FLD_LO +: 2] = 2'h0;
         wrMask[VECTOR_BIT]         = 1'b0;
         if (!wide) begin
            res1[VECTOR_BIT] = 1'b1;
         end
      end
      if (!activityMonitorPresent) begin
         wrMask[AMU_BIT] = 1'b0;
      end
      // Bit 20 is the float field in the wide view, so only the live layout's trace bit is pinned
      if (!traceSysregPresent) begin
         if (wide) begin
            wrMask[TRC_BIT_WIDE] = 1'b0;
         end else begin
            wrMask[TRC_BIT_NARROW] = 1'b0;
         end
      end
      // Wide and narrow views share the storage bits that exist in both
      trcBit  = wide ? stateFf.ctrl[TRC_BIT_WIDE] : stateFf.ctrl[TRC_BIT_NARROW];
      mtxTrap = wide ? fld_traps(stateFf.ctrl[MATRIX_FLD_LO +: 2], instEl, hostTrapGeneral)
                     : stateFf.ctrl[MATRIX_BIT];
      vecTrap = wide ? fld_traps(stateFf.ctrl[VECTOR_FLD_LO +: 2], instEl, hostTrapGeneral)
                     : stateFf.ctrl[VECTOR_BIT];
      fltTrap = wide ? fld_traps(stateFf.ctrl[FLOAT_FLD_LO +: 2], instEl, hostTrapGeneral)
                     : stateFf.ctrl[FLOAT_BIT];
      isTraceEnc = instState32 || ((instOp0 == OP0_TRACE) && (instOp1 == OP1_TRACE) && (instCrn < CRN_TRACE_LIM));
      fltCls = 1'b0;

      nxtState       = stateFf;
      nxtState.trap  = 1'b0;
      nxtState.ec    = EC_NONE;
      nxtState.syndrome_detail   = ISS_MATRIX;
      nxtState.undef = 1'b0;
      nxtState.side  = 1'b0;
      // Register write only touches implemented bits
      if (regWrEn) begin
         nxtState.ctrl = (regWrData & wrMask) | (stateFf.ctrl & ~wrMask);
      end
      // Field storage never drives register validity, only verdicts
      if (instValid && el2Enabled) begin
         case (instClass)
            ICLS_MATRIX, ICLS_SMODE_IMM: begin
               if (mtxTrap && matrixFeaturePresent) begin
                  nxtState.trap = 1'b1;
                  nxtState.ec   = EC_MATRIX;
               end else begin
                  fltCls = 1'b1;
               end
            end
            ICLS_VECTOR: begin
               if (vecTrap && vectorFeaturePresent) begin
                  nxtState.trap = 1'b1;
                  nxtState.ec   = EC_VECTOR;
               end else begin
                  fltCls = 1'b1;
               end
            end
            ICLS_FLOAT: fltCls = 1'b1;
            ICLS_FLOAT_ID: begin
               if (instEl == EL0) begin
                  nxtState.undef = 1'b1;
               end else begin
                  fltCls = 1'b1;
               end
            end
            ICLS_FLOAT_ID_WR: begin
               if (instEl != EL0) begin
                  fltCls = 1'b1;
               end else begin
                  nxtState.undef = 1'b1;
               end
            end
            ICLS_ACR: begin
               if (stateFf.ctrl[ACR_BIT] && !hostTrapGeneral && (instEl == EL1)) begin
                  nxtState.trap = 1'b1;
                  nxtState.ec   = instState32 ? EC_WIDE32 : EC_SYSREG64;
               end
            end
            ICLS_AMU, ICLS_AMU_PAIR: begin
               if (stateFf.ctrl[AMU_BIT] && activityMonitorPresent && (instEl != EL2)) begin
                  nxtState.trap = 1'b1;
                  nxtState.ec   = !instState32 ? EC_SYSREG64
                                : (instClass == ICLS_AMU_PAIR) ? EC_PAIR32 : EC_WIDE32;
               end
            end
            ICLS_TRACE: begin
               if ((instEl == EL0) && traceEl0Forbidden) begin
                  nxtState.undef = 1'b1;
               end else if (trcBit && traceSysregPresent && isTraceEnc) begin
                  nxtState.trap = 1'b1;
                  nxtState.ec   = instState32 ? EC_TRACE32 : EC_SYSREG64;
               end else begin
                  nxtState.side = 1'b1;
               end
            end
            default: begin
            end
         endcase
         if (fltCls && fltTrap) begin
            nxtState.trap = 1'b1;
            nxtState.ec   = EC_FLOAT;
         end
      end else if (instValid && (instClass == ICLS_TRACE)) begin
         nxtState.side = !((instEl == EL0) && traceEl0Forbidden);
      end
      nxtState.rd = (nxtState.ctrl & wrMask) | res1;
   end

   // Reset value is arbitrary: architecture leaves the fields unknown
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stateFf <= '0;
      end else begin
         stateFf <= nxtState;
      end
   end

   assign regRdData      = stateFf.rd;
   assign trapValid      = stateFf.trap;
   assign exceptionClass = stateFf.ec;
   assign syndromeDetail = stateFf.syndrome_detail;
   assign undefValid     = stateFf.undef;
   assign sideEffectEn   = stateFf.side;

   chk_matrix_ec_code: assert property (@(posedge clk) disable iff (!rst_n)
      (trapValid && exceptionClass == EC_MATRIX) |-> syndromeDetail == ISS_MATRIX)
      else $error("matrix trap with nonzero syndrome");
   chk_trap_undef_excl: assert property (@(posedge clk) disable iff (!rst_n)
      !(trapValid && undefValid)) else $error("trap and undefined together");
   chk_trace_no_side: assert property (@(posedge clk) disable iff (!rst_n)
      trapValid |-> !sideEffectEn) else $error("side effect on trapped access");
   chk_acr_tge_off: assert property (@(posedge clk) disable iff (!rst_n)
      (instValid && instClass == ICLS_ACR && hostTrapGeneral) |=> !trapValid)
      else $error("access control trap under TGE");
   chk_narrow_float_bit: assert property (@(posedge clk) disable iff (!rst_n)
      (instValid && el2Enabled && !(hostExtensionPresent && hostInEl2) && instClass == ICLS_FLOAT
       && stateFf.ctrl[FLOAT_BIT]) |=> (trapValid && exceptionClass == EC_FLOAT))
      else $error("single-bit float trap missed");
   chk_wide_all_traps: assert property (@(posedge clk) disable iff (!rst_n)
      (instValid && el2Enabled && wide && instClass == ICLS_FLOAT && instEl == EL2
       && stateFf.ctrl[FLOAT_FLD_LO +: 2] != ENC_TRAP_NONE && stateFf.ctrl[FLOAT_FLD_LO +: 2] != ENC_TRAP_EL0
       && !regWrEn) |=> (trapValid && exceptionClass == EC_FLOAT)) else $error("float trap missed");
   chk_vec_over_flt: assert property (@(posedge clk) disable iff (!rst_n)
      (instValid && el2Enabled && instClass == ICLS_VECTOR && vecTrap && vectorFeaturePresent)
      |=> exceptionClass == EC_VECTOR) else $error("vector trap lost priority");
   chk_res1_reads: assert property (@(posedge clk) disable iff (!rst_n)
      ($past(!hostInEl2) && $past(!regWrEn)) |-> (regRdData[7:0] == 8'hFF))
      else $error("reserved-one bits not read as one");
   chk_undef_el0_trace: assert property (@(posedge clk) disable iff (!rst_n)
      (instValid && instClass == ICLS_TRACE && instEl == EL0 && traceEl0Forbidden && el2Enabled)
      |=> (undefValid && !trapValid)) else $error("EL0 trace not undefined");
   cov_matrix_trap: cover property (@(posedge clk) trapValid && exceptionClass == EC_MATRIX);
   cov_float_trap: cover property (@(posedge clk) trapValid && exceptionClass == EC_FLOAT);
   cov_amu_pair: cover property (@(posedge clk) trapValid && exceptionClass == EC_PAIR32);
endmodule

/* tb/ftc_decode_model.sv */
/*
 Decode pipeline model: presents one classified query per call.
 Assumes it is called from the bench and driven on the falling edge.
*/
`timescale 1ns/1ps
module ftc_decode_model
   import ftc_pkg::*;
(
   input  wire logic clk,
   output logic       instValid,
   output ftc_icls_t  instClass,
   output logic [1:0] instEl,
   output logic       instState32,
   output logic [1:0] instOp0,
   output logic [2:0] instOp1,
   output logic [3:0] instCrn
);
   initial begin
      instValid = 1'b0;
      instClass = ICLS_NONE;
      instEl = EL0;
      instState32 = 1'b0;
      instOp0 = OP0_TRACE;
      instOp1 = OP1_TRACE;
      instCrn = 4'h0;
   end

   // Fields stand for the taken edge only, then valid and class drop and CRn is scrambled
   task automatic query(input ftc_icls_t c, input logic [1:0] el, input logic s, input logic [3:0] crn);
      @(negedge clk);
      instValid = 1'b1;
      instClass = c;
      instEl = el;
      instState32 = s;
      instCrn = crn;
      @(negedge clk);
      instValid = 1'b0;
      instClass = ICLS_NONE;
      instCrn = ~crn;
   endtask
endmodule

/* tb/ftc_el2_feature_trap_control_tb_top.sv */
/*
 Bench for the EL2 feature trap control: register layouts and verdicts.
 Assumes verdicts show one cycle after the query edge.
*/
`timescale 1ns/1ps
module ftc_el2_feature_trap_control_tb_top;
   import ftc_pkg::*;
   logic clk, rst_n, hostInEl2, hostTrapGeneral, el2Enabled, traceEl0Forbidden, traceSysregPresent;
   logic regWrEn, instValid, instState32, trapValid, undefValid, sideEffectEn;
   logic [63:0] regWrData, regRdData;
   ftc_icls_t   instClass;
   logic [1:0]  instEl, instOp0;
   logic [2:0]  instOp1;
   logic [3:0]  instCrn;
   logic [5:0]  exceptionClass;
   logic [24:0] syndromeDetail;
   int fail_count = 0;
   int comparisons = 0;

   ftc_decode_model pipe (.clk(clk), .instValid(instValid), .instClass(instClass), .instEl(instEl),
      .instState32(instState32), .instOp0(instOp0), .instOp1(instOp1), .instCrn(instCrn));
   ftc_el2_feature_trap_control dut (.clk(clk), .rst_n(rst_n), .matrixFeaturePresent(1'b1),
      .vectorFeaturePresent(1'b1), .hostExtensionPresent(1'b1), .activityMonitorPresent(1'b1),
      .traceSysregPresent(traceSysregPresent), .hostInEl2(hostInEl2), .hostTrapGeneral(hostTrapGeneral),
      .el2Enabled(el2Enabled), .traceEl0Forbidden(traceEl0Forbidden), .regWrEn(regWrEn),
      .regWrData(regWrData), .instValid(instValid), .instClass(instClass), .instEl(instEl),
      .instState32(instState32), .instOp0(instOp0), .instOp1(instOp1), .instCrn(instCrn),
      .regRdData(regRdData), .trapValid(trapValid), .exceptionClass(exceptionClass),
      .syndromeDetail(syndromeDetail), .undefValid(undefValid), .sideEffectEn(sideEffectEn));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic results();
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
      comparisons++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask

   // Extra edge after the strobe so readback has landed
   task automatic wr(input logic [63:0] d);
      @(negedge clk);
      regWrEn = 1'b1;
      regWrData = d;
      @(negedge clk);
      regWrEn = 1'b0;
      @(negedge clk);
   endtask

   task automatic qc(input ftc_icls_t c, input logic [1:0] el, input logic s, input logic [3:0] crn,
                     input logic tr, input logic [5:0] ec, input logic ud);
      pipe.query(c, el, s, crn);
      chk("trapValid", 64'(tr), 64'(trapValid));
      chk("exceptionClass", 64'(tr ? ec : EC_NONE), 64'(exceptionClass));
      chk("syndromeDetail", 64'(ISS_MATRIX), 64'(syndromeDetail));
      chk("undefValid", 64'(ud), 64'(undefValid));
   endtask

   task automatic s_reg();
      chk("rd_reset", RESET_VALUE, regRdData);
      wr('1);
      chk("rd_wide", WIDE_WR_MASK, regRdData);
      hostInEl2 = 1'b0;
      wr('1);
      chk("rd_narrow", NARROW_WR_MASK | NARROW_RES1, regRdData);
      hostInEl2 = 1'b1;
      traceSysregPresent = 1'b0;
      wr('1);
      chk("rd_notrace", WIDE_WR_MASK & ~(64'h1 << TRC_BIT_WIDE), regRdData);
      traceSysregPresent = 1'b1;
      rst_n = 1'b0;
      @(negedge clk);
      chk("rd_in_reset", 64'h0, regRdData);
      rst_n = 1'b1;
      @(negedge clk);
   endtask

   // Every encoding of each two-bit field, both TGE values, every level
   task automatic s_enc();
      int lo[3] = '{MATRIX_FLD_LO, VECTOR_FLD_LO, FLOAT_FLD_LO};
      ftc_icls_t cl[3] = '{ICLS_MATRIX, ICLS_VECTOR, ICLS_FLOAT};
      logic [5:0] ec[3] = '{EC_MATRIX, EC_VECTOR, EC_FLOAT};
      logic t;
      for (int f = 0; f < 3; f++) begin
         for (int e = 0; e < 4; e++) begin
            wr((64'h0333_0000 & ~(64'h3 << lo[f])) | (64'(e) << lo[f]));
            for (int g = 0; g < 2; g++) begin
               hostTrapGeneral = g[0];
               for (int l = 0; l < 3; l++) begin
                  t = (e == 0 || e == 2 || (e == 1 && g == 1 && l == 0));
                  qc(cl[f], l[1:0], 1'b0, 4'h0, t, ec[f], 1'b0);
               end
            end
         end
      end
      hostTrapGeneral = 1'b0;
   endtask

   task automatic s_prio();
      wr(64'h0);
      qc(ICLS_MATRIX, EL1, 1'b0, 4'h0, 1'b1, EC_MATRIX, 1'b0);
      qc(ICLS_VECTOR, EL1, 1'b0, 4'h0, 1'b1, EC_VECTOR, 1'b0);
      qc(ICLS_SMODE_IMM, EL0, 1'b0, 4'h0, 1'b1, EC_MATRIX, 1'b0);
      wr(64'h0300_0000);
      qc(ICLS_MATRIX, EL2, 1'b0, 4'h0, 1'b1, EC_FLOAT, 1'b0);
      hostInEl2 = 1'b0;
      wr(64'h1400);
      qc(ICLS_MATRIX, EL1, 1'b0, 4'h0, 1'b1, EC_MATRIX, 1'b0);
      wr(64'h0500);
      qc(ICLS_VECTOR, EL1, 1'b0, 4'h0, 1'b1, EC_VECTOR, 1'b0);
      wr(64'h0400);
      qc(ICLS_MATRIX, EL2, 1'b0, 4'h0, 1'b1, EC_FLOAT, 1'b0);
      qc(ICLS_FLOAT, EL0, 1'b1, 4'h0, 1'b1, EC_FLOAT, 1'b0);
      wr(64'h0);
      qc(ICLS_MATRIX, EL0, 1'b0, 4'h0, 1'b0, EC_NONE, 1'b0);
      wr(64'h1000);
      qc(ICLS_SMODE_IMM, EL2, 1'b0, 4'h0, 1'b1, EC_MATRIX, 1'b0);
      hostInEl2 = 1'b1;
   endtask

   task automatic s_sys();
      wr(64'hD333_0000);
      qc(ICLS_ACR, EL1, 1'b0, 4'h0, 1'b1, EC_SYSREG64, 1'b0);
      qc(ICLS_ACR, EL1, 1'b1, 4'h0, 1'b1, EC_WIDE32, 1'b0);
      hostTrapGeneral = 1'b1;
      qc(ICLS_ACR, EL1, 1'b0, 4'h0, 1'b0, EC_NONE, 1'b0);
      hostTrapGeneral = 1'b0;
      qc(ICLS_AMU, EL0, 1'b0, 4'h0, 1'b1, EC_SYSREG64, 1'b0);
      qc(ICLS_AMU, EL1, 1'b1, 4'h0, 1'b1, EC_WIDE32, 1'b0);
      qc(ICLS_AMU_PAIR, EL1, 1'b1, 4'h0, 1'b1, EC_PAIR32, 1'b0);
      qc(ICLS_AMU, EL2, 1'b0, 4'h0, 1'b0, EC_NONE, 1'b0);
      qc(ICLS_TRACE, EL1, 1'b0, 4'h7, 1'b1, EC_SYSREG64, 1'b0);
      chk("sideEffectEn", 64'h0, 64'(sideEffectEn));
      qc(ICLS_TRACE, EL1, 1'b0, 4'h8, 1'b0, EC_NONE, 1'b0);
      chk("sideEffectEn", 64'h1, 64'(sideEffectEn));
      qc(ICLS_TRACE, EL2, 1'b1, 4'h0, 1'b1, EC_TRACE32, 1'b0);
      traceEl0Forbidden = 1'b1;
      qc(ICLS_TRACE, EL0, 1'b0, 4'h1, 1'b0, EC_NONE, 1'b1);
      traceEl0Forbidden = 1'b0;
      wr(64'hD303_0000);
      qc(ICLS_FLOAT_ID, EL0, 1'b1, 4'h0, 1'b0, EC_NONE, 1'b1);
      qc(ICLS_FLOAT_ID_WR, EL1, 1'b1, 4'h0, 1'b1, EC_FLOAT, 1'b0);
      el2Enabled = 1'b0;
      qc(ICLS_FLOAT, EL1, 1'b0, 4'h0, 1'b0, EC_NONE, 1'b0);
      el2Enabled = 1'b1;
   endtask

   initial begin
      rst_n = 1'b0;
      hostInEl2 = 1'b1;
      hostTrapGeneral = 1'b0;
      el2Enabled = 1'b1;
      traceEl0Forbidden = 1'b0;
      traceSysregPresent = 1'b1;
      regWrEn = 1'b0;
      regWrData = 64'h0;
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      s_reg();
      s_enc();
      s_prio();
      s_sys();
      results();
   end

   // About 270 cycles expected; over twenty times that is a hang
   initial begin
      #24000;
      fail_count++;
      results();
   end
endmodule
